// >>> common/serial_port_map.svh
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

// system clock and default bit rate
`define CLK_HZ 100000000
`define DEFAULT_BAUD 9600
`define DEFAULT_DIV ((`CLK_HZ + `DEFAULT_BAUD - 1) / `DEFAULT_BAUD)
`define DIV_W 20
`define MIN_DIV 20'h00008
`define DIV_ONE 20'h00001

// register byte offsets
`define ADDR_W 12
`define DATA_OFS 12'h000
`define STATUS_OFS 12'h004
`define CTRL_OFS 12'h008
`define BAUD_OFS 12'h00C

// control fields
`define CTRL_W 7
`define CTRL_RESET 7'h11
`define CTRL_EIGHT 0
`define CTRL_PAR_EN 1
`define CTRL_PAR_ODD 2
`define CTRL_TWO_STOP 3
`define CTRL_FLOW_EN 4
`define CTRL_DTR 5
`define CTRL_RTS 6

// status fields
`define ST_TX_FULL 0
`define ST_TX_EMPTY 1
`define ST_RX_AVAIL 2
`define ST_TX_ACTIVE 3
`define ST_OVERRUN 4
`define ST_FRAMING 5
`define ST_PARITY 6
`define ST_CTS 7
`define ST_DSR 8
`define ST_DCD 9
`define ST_RI 10

// synchroniser lanes
`define PIN_N 5
`define PIN_RXD 0
`define PIN_CTS 1
`define PIN_DSR 2
`define PIN_DCD 3
`define PIN_RI 4

// fifo shape and bit counts
`define FIFO_W 8
`define FIFO_D 8
`define LAST_BIT8 3'h7
`define LAST_BIT7 3'h6

`endif

// >>> common/serial_port_pkg.sv
package serial_port_pkg;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_LEAD,
        TX_START,
        TX_DATA,
        TX_PARITY,
        TX_STOP,
        TX_TRAIL
    } tx_state_type;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PARITY,
        RX_STOP
    } rx_state_type;

endpackage : serial_port_pkg

// >>> logic/async_serial_port_flow_ctrl.sv
// Operation
// R1 - bit rate programmable from 183 baud up to 6 Mbaud
// R2 - bit period never shorter than eight system clock cycles
// R3 - ceilings: 48 MHz 6 Mbaud, 24 MHz 3 Mbaud, 12 MHz 1.5 Mbaud
// R4 - frame: start bit, 7 or 8 data, optional parity, 1 or 2 stop
// R5 - data bits sent least significant first, right after start bit
// R6 - bit rate is 9600 baud after reset
// R7 - rts/cts flow control enabled after reset
// R8 - format after reset: eight data bits, no parity, one stop bit
// R9 - rate, flow, data bits, parity, stop bits all writable at run time
// R10 - transmit-active output marks outgoing transmission for rs485 driver
// R11 - standard async serial port with flow control via line transceivers
// R12 - transmit-active rises one bit before data, falls one bit after frame
// R13 - drive rts_n and dtr_n, sample cts_n, dcd_n, dsr_n, ring_indicate_n
// R14 - with flow control on, no new frame while cts deasserted
// R15 - receiver: falling start edge, centre sampling, framing error on low stop
`timescale 1ns/10ps
`include "serial_port_map.svh"

module async_serial_port_flow_ctrl #(
    parameter logic [`DIV_W-1:0] BAUD_DIV_RESET = `DIV_W'(`DEFAULT_DIV)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic txd,
    input wire logic rxd,
    output logic rts_n,
    input wire logic cts_n,
    output logic dtr_n,
    input wire logic dsr_n,
    input wire logic dcd_n,
    input wire logic ring_indicate_n,
    output logic tx_active
);
    logic [`PIN_N-1:0] pins_in, sync1_r, sync2_r;
    logic [`CTRL_W-1:0] ctrl_r;
    logic [`DIV_W-1:0] baud_r, div_eff, div_half, tx_cnt_r, rx_cnt_r;
    logic [31:0] prdata_r, status_word, read_mux;
    logic [`FIFO_W-1:0] tx_out_data, rx_out_data, rx_data_r;
    logic [7:0] tx_shift_r, tx_masked, rx_shift_r;
    logic [2:0] tx_bit_r, last_bit, rx_bit_r;
    logic setup_ph, access_ph, addr_ok, hit_data, wr_en, clr_wr, tx_push, tx_pop, tx_in_ready;
    logic tx_out_valid, rx_in_ready, rx_out_valid, rx_pop, overrun_r, framing_r, parity_r;
    logic rts_n_r, dtr_n_r, cts_ok, rx_line, rx_prev_r, tx_bit_end, tx_par_r, txd_r, tx_active_r;
    logic rx_bit_end, rx_half_end, rx_par_acc_r, rx_perr_r, rx_done_r, rx_ferr_r, rx_perr_ev_r;
    serial_port_pkg::tx_state_type tx_state_r;
    serial_port_pkg::rx_state_type rx_state_r;

    // two flops on every pin, lanes in PIN_ order; only the second stage is used
    assign pins_in = {ring_indicate_n, dcd_n, dsr_n, cts_n, rxd};
    for (genvar g = 0; g < `PIN_N; g++) begin : g_sync
        // idle-high line and deasserted modem inputs at reset
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync1_r[g] <= 1'b1;
                sync2_r[g] <= 1'b1;
            end else begin
                sync1_r[g] <= pins_in[g]; // see R13
                sync2_r[g] <= sync1_r[g];
            end
        end
    end

    assign rx_line = sync2_r[`PIN_RXD];
    assign cts_ok = !ctrl_r[`CTRL_FLOW_EN] || !sync2_r[`PIN_CTS]; // see R14
    // clamp keeps the period at eight clocks minimum, so clk/8 is the ceiling
    assign div_eff = (baud_r < `MIN_DIV) ? `MIN_DIV : baud_r; // see R2
    assign div_half = div_eff >> 1;
    assign last_bit = ctrl_r[`CTRL_EIGHT] ? `LAST_BIT8 : `LAST_BIT7; // see R4
    // apb decode; only a data write into a full fifo stretches the access
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign hit_data = (paddr == `DATA_OFS);
    assign addr_ok = hit_data || (paddr == `STATUS_OFS) || (paddr == `CTRL_OFS)
                     || (paddr == `BAUD_OFS);
    assign pready = !(access_ph && pwrite && hit_data && !tx_in_ready);
    assign pslverr = access_ph && !addr_ok;
    assign wr_en = access_ph && pwrite && pready;
    assign tx_push = wr_en && hit_data;
    assign rx_pop = access_ph && !pwrite && hit_data && rx_out_valid;
    assign clr_wr = wr_en && (paddr == `STATUS_OFS);
    assign prdata = prdata_r;
    // status word; unused bits read zero
    always_comb begin
        status_word = 32'h00000000;
        status_word[`ST_TX_FULL] = !tx_in_ready;
        status_word[`ST_TX_EMPTY] = !tx_out_valid;
        status_word[`ST_RX_AVAIL] = rx_out_valid;
        status_word[`ST_TX_ACTIVE] = tx_active_r;
        status_word[`ST_OVERRUN] = overrun_r;
        status_word[`ST_FRAMING] = framing_r;
        status_word[`ST_PARITY] = parity_r;
        status_word[`ST_CTS] = !sync2_r[`PIN_CTS]; // see R13
        status_word[`ST_DSR] = !sync2_r[`PIN_DSR];
        status_word[`ST_DCD] = !sync2_r[`PIN_DCD];
        status_word[`ST_RI] = !sync2_r[`PIN_RI];
    end
    // read mux, sampled in the setup cycle so prdata comes from a flop
    always_comb begin
        read_mux = 32'h00000000;
        unique case (paddr)
            `DATA_OFS: read_mux = {24'h000000, rx_out_valid ? rx_out_data : 8'h00};
            `STATUS_OFS: read_mux = status_word;
            `CTRL_OFS: read_mux = {25'h0000000, ctrl_r};
            `BAUD_OFS: read_mux = {12'h000, baud_r};
            default: read_mux = 32'h00000000;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (setup_ph && !pwrite) begin
            prdata_r <= read_mux;
        end
    end

    // configuration; format changes take effect at once, not at a frame boundary,
    // so a mid-frame change may corrupt that one frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RESET; // see R7 see R8
            baud_r <= BAUD_DIV_RESET; // see R6
        end else if (wr_en) begin
            if (paddr == `CTRL_OFS) begin
                ctrl_r <= pwdata[`CTRL_W-1:0]; // see R9
            end
            if (paddr == `BAUD_OFS) begin
                baud_r <= pwdata[`DIV_W-1:0]; // see R1 see R3
            end
        end
    end

    // sticky errors, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_r <= 1'b0;
            framing_r <= 1'b0;
            parity_r <= 1'b0;
        end else begin
            overrun_r <= (rx_done_r && !rx_in_ready)
                         || (overrun_r && !(clr_wr && pwdata[`ST_OVERRUN]));
            framing_r <= (rx_done_r && rx_ferr_r)
                         || (framing_r && !(clr_wr && pwdata[`ST_FRAMING])); // see R15
            parity_r <= (rx_done_r && rx_perr_ev_r)
                        || (parity_r && !(clr_wr && pwdata[`ST_PARITY]));
        end
    end

    // modem outputs; with flow on, rts follows room in the receive fifo
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_n_r <= 1'b1;
            dtr_n_r <= 1'b1;
        end else begin
            rts_n_r <= ctrl_r[`CTRL_FLOW_EN] ? !rx_in_ready : !ctrl_r[`CTRL_RTS]; // see R13
            dtr_n_r <= !ctrl_r[`CTRL_DTR];
        end
    end

    assign rts_n = rts_n_r;
    assign dtr_n = dtr_n_r;
    assign txd = txd_r; // see R11
    assign tx_active = tx_active_r;
    fifo_buffer #(
        .WIDTH(`FIFO_W),
        .DEPTH(`FIFO_D)
    ) u_tx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(tx_push),
        .in_data(pwdata[`FIFO_W-1:0]),
        .in_ready(tx_in_ready),
        .out_valid(tx_out_valid),
        .out_data(tx_out_data),
        .out_ready(tx_pop)
    );
    fifo_buffer #(
        .WIDTH(`FIFO_W),
        .DEPTH(`FIFO_D)
    ) u_rx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(rx_done_r && rx_in_ready),
        .in_data(rx_data_r),
        .in_ready(rx_in_ready),
        .out_valid(rx_out_valid),
        .out_data(rx_out_data),
        .out_ready(rx_pop)
    );

    // bit timer; >= so a divider cut mid-bit cannot strand the count
    assign tx_bit_end = (tx_cnt_r >= div_eff - `DIV_ONE);
    assign tx_pop = (tx_state_r == serial_port_pkg::TX_IDLE) && tx_out_valid && cts_ok;
    assign tx_masked = ctrl_r[`CTRL_EIGHT] ? tx_out_data : {1'b0, tx_out_data[6:0]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_r <= '0;
        end else if (tx_state_r == serial_port_pkg::TX_IDLE || tx_bit_end) begin
            tx_cnt_r <= '0;
        end else begin
            tx_cnt_r <= tx_cnt_r + `DIV_ONE;
        end
    end

    // transmitter; active covers one bit before the start bit and one after stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_r <= serial_port_pkg::TX_IDLE;
            tx_bit_r <= 3'h0;
            tx_shift_r <= 8'h00;
            tx_par_r <= 1'b0;
            txd_r <= 1'b1;
            tx_active_r <= 1'b0;
        end else begin
            unique case (tx_state_r)
                serial_port_pkg::TX_IDLE: begin
                    if (tx_pop) begin // see R14
                        tx_shift_r <= tx_masked;
                        tx_par_r <= (^tx_masked) ^ ctrl_r[`CTRL_PAR_ODD];
                        tx_active_r <= 1'b1; // see R10 see R12
                        tx_state_r <= serial_port_pkg::TX_LEAD;
                    end
                end
                serial_port_pkg::TX_LEAD: begin
                    if (tx_bit_end) begin
                        txd_r <= 1'b0; // see R4
                        tx_state_r <= serial_port_pkg::TX_START;
                    end
                end
                serial_port_pkg::TX_START: begin
                    if (tx_bit_end) begin
                        txd_r <= tx_shift_r[0]; // see R5
                        tx_bit_r <= 3'h0;
                        tx_state_r <= serial_port_pkg::TX_DATA;
                    end
                end
                serial_port_pkg::TX_DATA: begin
                    if (tx_bit_end) begin
                        if (tx_bit_r == last_bit) begin
                            if (ctrl_r[`CTRL_PAR_EN]) begin
                                txd_r <= tx_par_r;
                                tx_state_r <= serial_port_pkg::TX_PARITY;
                            end else begin
                                txd_r <= 1'b1;
                                tx_bit_r <= 3'h0;
                                tx_state_r <= serial_port_pkg::TX_STOP;
                            end
                        end else begin
                            txd_r <= tx_shift_r[1]; // see R5
                            tx_shift_r <= tx_shift_r >> 1;
                            tx_bit_r <= tx_bit_r + 3'h1;
                        end
                    end
                end
                serial_port_pkg::TX_PARITY: begin
                    if (tx_bit_end) begin
                        txd_r <= 1'b1;
                        tx_bit_r <= 3'h0;
                        tx_state_r <= serial_port_pkg::TX_STOP;
                    end
                end
                serial_port_pkg::TX_STOP: begin
                    if (tx_bit_end) begin
                        if (ctrl_r[`CTRL_TWO_STOP] && tx_bit_r == 3'h0) begin
                            tx_bit_r <= 3'h1; // see R4
                        end else begin
                            tx_state_r <= serial_port_pkg::TX_TRAIL;
                        end
                    end
                end
                serial_port_pkg::TX_TRAIL: begin
                    if (tx_bit_end) begin
                        tx_active_r <= 1'b0; // see R12
                        tx_state_r <= serial_port_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end

    // receive bit timer: half a bit to the start centre, then whole bits
    assign rx_bit_end = (rx_cnt_r >= div_eff - `DIV_ONE);
    assign rx_half_end = (rx_cnt_r >= div_half - `DIV_ONE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_r <= '0;
            rx_prev_r <= 1'b1;
        end else begin
            rx_prev_r <= rx_line;
            if (rx_state_r == serial_port_pkg::RX_IDLE || rx_bit_end
                || (rx_state_r == serial_port_pkg::RX_START && rx_half_end)) begin
                rx_cnt_r <= '0;
            end else begin
                rx_cnt_r <= rx_cnt_r + `DIV_ONE;
            end
        end
    end

    // receiver; only the first stop bit is checked so a back-to-back
    // start edge right after it is never missed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_r <= serial_port_pkg::RX_IDLE;
            rx_bit_r <= 3'h0;
            rx_shift_r <= 8'h00;
            rx_par_acc_r <= 1'b0;
            rx_perr_r <= 1'b0;
            rx_done_r <= 1'b0;
            rx_ferr_r <= 1'b0;
            rx_perr_ev_r <= 1'b0;
            rx_data_r <= 8'h00;
        end else begin
            rx_done_r <= 1'b0;
            unique case (rx_state_r)
                serial_port_pkg::RX_IDLE: begin
                    if (rx_prev_r && !rx_line) begin // see R15
                        rx_par_acc_r <= 1'b0;
                        rx_perr_r <= 1'b0;
                        rx_state_r <= serial_port_pkg::RX_START;
                    end
                end
                serial_port_pkg::RX_START: begin
                    if (rx_half_end) begin
                        rx_bit_r <= 3'h0;
                        // a glitch that is high again at mid-bit is not a start
                        rx_state_r <= rx_line ? serial_port_pkg::RX_IDLE
                                              : serial_port_pkg::RX_DATA;
                    end
                end
                serial_port_pkg::RX_DATA: begin
                    if (rx_bit_end) begin
                        rx_shift_r <= {rx_line, rx_shift_r[7:1]}; // see R5
                        rx_par_acc_r <= rx_par_acc_r ^ rx_line;
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == last_bit) begin
                            rx_state_r <= ctrl_r[`CTRL_PAR_EN] ? serial_port_pkg::RX_PARITY
                                                               : serial_port_pkg::RX_STOP;
                        end
                    end
                end
                serial_port_pkg::RX_PARITY: begin
                    if (rx_bit_end) begin
                        rx_perr_r <= rx_line ^ rx_par_acc_r ^ ctrl_r[`CTRL_PAR_ODD];
                        rx_state_r <= serial_port_pkg::RX_STOP;
                    end
                end
                serial_port_pkg::RX_STOP: begin
                    if (rx_bit_end) begin
                        rx_done_r <= 1'b1;
                        rx_ferr_r <= !rx_line; // see R15
                        rx_perr_ev_r <= rx_perr_r;
                        rx_data_r <= ctrl_r[`CTRL_EIGHT] ? rx_shift_r
                                                         : {1'b0, rx_shift_r[7:1]};
                        rx_state_r <= serial_port_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

endmodule : async_serial_port_flow_ctrl

// >>> logic/fifo_buffer.sv
`timescale 1ns/10ps

module fifo_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // full and empty come straight from the occupancy count
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage, no reset needed on the data words
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + 1'b1;
        end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
        end
    end

endmodule : fifo_buffer

// >>> sim/async_serial_port_flow_ctrl_test.sv
`timescale 1ns/10ps
`include "serial_port_map.svh"

module async_serial_port_flow_ctrl_test;
    localparam int DIV = 16;
    logic pclk, presetn, psel, penable, pwrite, rxd, cts_n, dsr_n, dcd_n, ring_indicate_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, txd, rts_n, dtr_n, tx_active, rerr, ok;
    logic [7:0] d;
    int failures = 0;
    int n_compared = 0;

    async_serial_port_flow_ctrl #(.BAUD_DIV_RESET(20'h00010)) i_async_serial_port_flow_ctrl (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n),
        .dtr_n(dtr_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ring_indicate_n(ring_indicate_n),
        .tx_active(tx_active));
    serial_partner i_serial_partner (.pclk(pclk), .txd(txd), .rxd(rxd), .cts_n(cts_n),
        .dsr_n(dsr_n), .dcd_n(dcd_n), .ring_indicate_n(ring_indicate_n));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer, waits on pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, v};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_defaults();
        i_serial_partner.hold(4'h2);
        repeat (4) @(posedge pclk);
        apb(0, `CTRL_OFS, 0); chk("ctrl", 32'h11, rdat);
        apb(0, `BAUD_OFS, 0); chk("baud", DIV, rdat);
        apb(0, `STATUS_OFS, 0); chk("modem", 4'hB, rdat[10:7]);
        chk("rts_n", 0, rts_n);
        chk("dtr_n", 1, dtr_n);
        apb(1, `CTRL_OFS, 32'h31);
        repeat (2) @(posedge pclk); chk("dtr_n on", 0, dtr_n);
        apb(1, `CTRL_OFS, 32'h11);
        $display("defaults done");
    endtask : t_defaults

    task automatic t_tx();
        apb(1, `DATA_OFS, 32'hA5);
        i_serial_partner.recv(d, ok, DIV, 8, 0, 1);
        chk("tx byte", 8'hA5, d);
        chk("tx frame", 1, ok);
        chk("active in stop", 1, tx_active);
        repeat (2 * DIV) @(posedge pclk); chk("active off", 0, tx_active);
        $display("tx done");
    endtask : t_tx

    // seven bits, even parity, two stops, flow off
    task automatic t_format();
        apb(1, `CTRL_OFS, 32'h0A);
        apb(1, `DATA_OFS, 32'h35);
        i_serial_partner.recv(d, ok, DIV, 7, 1, 2);
        chk("fmt byte", 8'h35, d);
        chk("fmt frame", 1, ok);
        chk("rts_n off", 1, rts_n);
        apb(1, `CTRL_OFS, 32'h11);
        $display("format done");
    endtask : t_format

    // a divider below eight is held at eight
    task automatic t_baud();
        int b[2] = '{32, 4};
        int e[2] = '{32, 8};
        for (int i = 0; i < 2; i++) begin
            apb(1, `BAUD_OFS, b[i]);
            apb(1, `DATA_OFS, 32'h3C);
            i_serial_partner.recv(d, ok, e[i], 8, 0, 1);
            chk("baud byte", 8'h3C, d);
            chk("baud frame", 1, ok);
        end
        apb(1, `BAUD_OFS, DIV);
        $display("baud done");
    endtask : t_baud

    task automatic t_flow();
        i_serial_partner.hold(4'hA);
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 8; i++) apb(1, `DATA_OFS, i * 17);
        repeat (3 * DIV) @(posedge pclk);
        chk("held off", 0, tx_active);
        apb(0, `STATUS_OFS, 0); chk("tx full", 1, rdat[0]);
        i_serial_partner.hold(4'h2);
        for (int i = 0; i < 8; i++) begin
            i_serial_partner.recv(d, ok, DIV, 8, 0, 1);
            chk("fifo order", i * 17, d);
        end
        $display("flow done");
    endtask : t_flow

    task automatic t_rx();
        i_serial_partner.send(8'h5A, DIV, 1'b1);
        repeat (4) @(posedge pclk);
        apb(0, `STATUS_OFS, 0); chk("rx avail", 1, rdat[2]);
        apb(0, `DATA_OFS, 0); chk("rx byte", 8'h5A, rdat);
        i_serial_partner.send(8'hC3, DIV, 1'b0);
        repeat (4) @(posedge pclk);
        apb(0, `STATUS_OFS, 0); chk("framing", 1, rdat[5]);
        apb(1, `STATUS_OFS, 32'h20);
        apb(0, `STATUS_OFS, 0); chk("framing clr", 0, rdat[5]);
        apb(0, `DATA_OFS, 0); chk("bad byte", 8'hC3, rdat);
        apb(1, 12'h010, 0); chk("unmapped wr", 1, rerr);
        apb(0, 12'h010, 0); chk("unmapped rd", 0, rdat);
        $display("rx done");
    endtask : t_rx

    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    // watchdog at 30000 cycles, well above the few thousand cycles of frames
    initial begin
        repeat (30000) @(posedge pclk);
        failures++;
        test_done();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults();
        t_tx();
        t_format();
        t_baud();
        t_flow();
        t_rx();
        test_done();
    end
endmodule : async_serial_port_flow_ctrl_test

// >>> sim/serial_partner.sv
`timescale 1ns/10ps

module serial_partner (
    input wire logic pclk,
    input wire logic txd,
    output logic rxd,
    output logic cts_n,
    output logic dsr_n,
    output logic dcd_n,
    output logic ring_indicate_n
);
    initial begin
        rxd = 1'b1;
        {cts_n, dsr_n, dcd_n, ring_indicate_n} = 4'h7;
    end

    // modem lines in order cts, dsr, dcd, ring
    task automatic hold(input logic [3:0] v);
        @(posedge pclk);
        {cts_n, dsr_n, dcd_n, ring_indicate_n} <= v;
    endtask : hold

    // start low, eight data lsb first, then the given stop level
    task automatic send(input logic [7:0] d, input int div, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            rxd <= f[i];
            repeat (div - 1) @(posedge pclk);
        end
        @(posedge pclk);
        rxd <= 1'b1;
    endtask : send

    // mid-bit sampling keeps clear of the edge where txd changes
    task automatic recv(output logic [7:0] d, output logic ok, input int div,
        input int nbits, input logic par, input int nstop);
        ok = 1'b1;
        d = 8'h00;
        @(negedge txd);
        repeat (div / 2) @(posedge pclk);
        if (txd !== 1'b0) ok = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            repeat (div) @(posedge pclk);
            d[i] = txd;
        end
        if (par) begin
            repeat (div) @(posedge pclk);
            if (txd !== ^d) ok = 1'b0;
        end
        for (int i = 0; i < nstop; i++) begin
            repeat (div) @(posedge pclk);
            if (txd !== 1'b1) ok = 1'b0;
        end
    endtask : recv
endmodule : serial_partner

// >>> sim/serial_port_props.sv
`timescale 1ns/10ps

module serial_port_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic txd,
    input wire logic tx_active
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // line rests high unless a frame is out
    property p_idle_high;
        !tx_active |-> txd;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("txd low while not active");
    property p_lead;
        $rose(tx_active) |-> txd [*8];
    endproperty
    a_lead: assert property (p_lead)
        else $error("lead bit too short");
    property p_trail;
        $fell(tx_active) |-> $past(txd, 1) && $past(txd, 8);
    endproperty
    a_trail: assert property (p_trail)
        else $error("trail bit not high");
    property p_start_framed;
        $fell(txd) |-> tx_active;
    endproperty
    a_start_framed: assert property (p_start_framed)
        else $error("frame sent without tx_active");
    // no bit shorter than eight clocks, whatever the divider
    property p_low_min;
        $fell(txd) |-> !txd [*8];
    endproperty
    a_low_min: assert property (p_low_min)
        else $error("low bit under eight clocks");
    property p_high_min;
        $rose(txd) && tx_active |-> txd [*8];
    endproperty
    a_high_min: assert property (p_high_min)
        else $error("high bit under eight clocks");
    property p_read_fast;
        psel && penable && !pwrite |-> pready;
    endproperty
    a_read_fast: assert property (p_read_fast)
        else $error("read access stalled");
    property p_map;
        psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h00C);
    endproperty
    a_map: assert property (p_map)
        else $error("slave error on wrong address");

    c_frame: cover property ($fell(tx_active));
    c_err: cover property (psel && penable && pslverr);
    c_stall: cover property (psel && penable && !pready);
endmodule : serial_port_props

bind async_serial_port_flow_ctrl serial_port_props i_serial_port_props (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .txd(txd), .tx_active(tx_active));
